// >>> rtl/opm_pkg.sv
// Purpose: shared constants and types for the operating mode power controller
// Assumes: one 100 MHz control clock
// Notes:   regulator code steps in 50 mV from a base voltage
package opm_pkg;
  typedef enum logic [2:0] {
    OPM_FULL_ON,
    OPM_ACTIVE,
    OPM_SLEEP,
    OPM_DEEP_SLEEP,
    OPM_HIBERNATE
  } opm_mode_t;

  localparam logic [1:0] REG_REGULATOR_FREQUENCY_FIELD_OFF   = 2'h0; // regulator shut off code
  localparam int         VSTEP_MV       = 50;   // core voltage step
  localparam int         VBASE_MV       = 850;  // voltage for code zero
  localparam logic [3:0] VLEVEL_RST     = 4'h7; // 1.2 V after reset
  localparam logic [1:0] REGULATOR_FREQUENCY_FIELD_RST       = 2'h3; // regulator running
  localparam logic [5:0] MULT_RST       = 6'h0a; // default ratio 10
endpackage

// >>> rtl/opm_ctrl.sv
// Purpose: operating mode sequencer for loop, clock gates and core power
// Assumes: all requests and wake inputs are pins, synchronised here
// Notes:   one request is taken per clock; wake events take priority
`timescale 1ns/100ps

module opm_ctrl #(
  parameter int MULT_W = 6
) (
  input  wire logic              mclk_i,
  input  wire logic              rstn_i,
  input  wire logic              pll_enable_i,
  input  wire logic              pll_bypass_i,
  input  wire logic [MULT_W-1:0] pll_mult_i,
  input  wire logic              req_sleep_i,
  input  wire logic              req_deep_sleep_i,
  input  wire logic              req_full_on_i,
  input  wire logic              req_active_i,
  input  wire logic [1:0]        reg_regulator_frequency_field_i,
  input  wire logic [3:0]        reg_vlevel_i,
  input  wire logic              reg_write_i,
  input  wire logic              wake_i,
  input  wire logic              rtc_irq_i,
  input  wire logic              reset_pin_i,
  output logic [2:0]             mode_o,
  output logic                   pll_en_o,
  output logic                   pll_bypass_o,
  output logic [MULT_W-1:0]      pll_mult_o,
  output logic                   core_clk_en_o,
  output logic                   sys_clk_en_o,
  output logic                   core_power_o,
  output logic [3:0]             core_vlevel_o,
  output logic                   dma_l1_allow_o,
  output logic                   async_block_o,
  output logic                   pins_hiz_o,
  output logic                   boot_start_o
);

  // pin inputs pass two flops; stage one feeds only stage two
  localparam int NS = 10;
  logic [NS-1:0] s1_r;
  logic [NS-1:0] s2_r;
  logic [NS-1:0] pin_vec;
  assign pin_vec = {pll_enable_i, pll_bypass_i, req_sleep_i,
                    req_deep_sleep_i, req_full_on_i, req_active_i,
                    reg_write_i, wake_i, rtc_irq_i, reset_pin_i};

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= pin_vec;
      s2_r <= s1_r;
    end
  end

  logic en_s, byp_s, rq_sl, rq_ds, rq_fo, rq_ac, wr_s, wake_s, rtc_s, rst_s;
  assign {en_s, byp_s, rq_sl, rq_ds, rq_fo, rq_ac, wr_s, wake_s, rtc_s,
          rst_s} = s2_r;

  // multi-bit settings pass two flops of their own, like the strobe, and the
  // second stage is taken only when the synchronised write strobe is seen
  logic [MULT_W-1:0] mult_d1_r, mult_d2_r;
  logic [1:0]        regulator_frequency_field_d1_r, regulator_frequency_field_d2_r;
  logic [3:0]        vl_d1_r,   vl_d2_r;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mult_d1_r <= '0;
      mult_d2_r <= '0;
      regulator_frequency_field_d1_r <= '0;
      regulator_frequency_field_d2_r <= '0;
      vl_d1_r   <= '0;
      vl_d2_r   <= '0;
    end else begin
      mult_d1_r <= pll_mult_i;
      mult_d2_r <= mult_d1_r;
      regulator_frequency_field_d1_r <= reg_regulator_frequency_field_i;
      regulator_frequency_field_d2_r <= regulator_frequency_field_d1_r;
      vl_d1_r   <= reg_vlevel_i;
      vl_d2_r   <= vl_d1_r;
    end
  end

  opm_pkg::opm_mode_t mode_r, mode_nxt;
  logic [MULT_W-1:0] mult_pend_r, mult_pend_nxt;
  logic [MULT_W-1:0] mult_r, mult_nxt;
  logic [3:0]        vl_r, vl_nxt;
  logic              boot_r, boot_nxt;

  // mode transitions; wake events beat software requests
  always_comb begin
    mode_nxt      = mode_r;
    mult_pend_nxt = mult_pend_r;
    mult_nxt      = mult_r;
    vl_nxt        = vl_r;
    boot_nxt      = 1'b0;
    if (wr_s) begin
      mult_pend_nxt = mult_d2_r;
      vl_nxt        = vl_d2_r;
    end
    case (mode_r)
      opm_pkg::OPM_FULL_ON, opm_pkg::OPM_ACTIVE: begin
        // only explicit requests leave these modes
        if (wr_s && regulator_frequency_field_d2_r == opm_pkg::REG_REGULATOR_FREQUENCY_FIELD_OFF) begin
          mode_nxt = opm_pkg::OPM_HIBERNATE;
        end else if (rq_ds) begin
          mode_nxt = opm_pkg::OPM_DEEP_SLEEP;
        end else if (rq_sl) begin
          mode_nxt = opm_pkg::OPM_SLEEP;
        end else if (mode_r == opm_pkg::OPM_FULL_ON && rq_ac) begin
          mode_nxt = opm_pkg::OPM_ACTIVE;
        end else if (mode_r == opm_pkg::OPM_ACTIVE && rq_fo) begin
          mode_nxt = opm_pkg::OPM_FULL_ON;
        end
      end
      opm_pkg::OPM_SLEEP: begin
        if (wake_s || rtc_s) begin
          mode_nxt = byp_s ? opm_pkg::OPM_ACTIVE
                           : opm_pkg::OPM_FULL_ON;
        end
      end
      opm_pkg::OPM_DEEP_SLEEP: begin
        if (rst_s) begin
          mode_nxt = opm_pkg::OPM_FULL_ON;
        end else if (rtc_s) begin
          mode_nxt = opm_pkg::OPM_ACTIVE;
        end
      end
      opm_pkg::OPM_HIBERNATE: begin
        if (rst_s || rtc_s) begin
          mode_nxt = opm_pkg::OPM_FULL_ON;
          boot_nxt = rst_s;
          vl_nxt   = opm_pkg::VLEVEL_RST;
        end
      end
      default: mode_nxt = opm_pkg::OPM_FULL_ON;
    endcase
    // new ratio lands as full-on is entered, or at once on a write while in full-on
    if (mode_nxt == opm_pkg::OPM_FULL_ON && mode_r != opm_pkg::OPM_FULL_ON)
    begin
      mult_nxt = mult_pend_nxt;
    end else if (mode_r == opm_pkg::OPM_FULL_ON && wr_s) begin
      mult_nxt = mult_d2_r;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_r      <= opm_pkg::OPM_FULL_ON;
      mult_pend_r <= MULT_W'(opm_pkg::MULT_RST);
      mult_r      <= MULT_W'(opm_pkg::MULT_RST);
      vl_r        <= opm_pkg::VLEVEL_RST;
      boot_r      <= 1'b0;
    end else begin
      mode_r      <= mode_nxt;
      mult_pend_r <= mult_pend_nxt;
      mult_r      <= mult_nxt;
      vl_r        <= vl_nxt;
      boot_r      <= boot_nxt;
    end
  end

  // per-mode profile decoded from the next mode, so outputs are flops
  logic [7:0] prof_nxt, prof_r;
  always_comb begin
    // {pll_en, bypass, core_clk, sys_clk, power, dma, async_blk, hiz}
    prof_nxt = 8'h00;
    case (mode_nxt)
      opm_pkg::OPM_FULL_ON:    prof_nxt = 8'b1_0_1_1_1_1_0_0;
      opm_pkg::OPM_ACTIVE:     prof_nxt = {en_s, 7'b1_1_1_1_1_0_0};
      opm_pkg::OPM_SLEEP:      prof_nxt = 8'b1_0_0_1_1_0_0_0;
      opm_pkg::OPM_DEEP_SLEEP: prof_nxt = 8'b0_0_0_0_1_0_1_0;
      opm_pkg::OPM_HIBERNATE:  prof_nxt = 8'b0_0_0_0_0_0_1_1;
      default:                 prof_nxt = 8'b1_0_1_1_1_1_0_0;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prof_r <= 8'b1_0_1_1_1_1_0_0;
    end else begin
      prof_r <= prof_nxt;
    end
  end

  assign mode_o         = mode_r;
  assign {pll_en_o, pll_bypass_o, core_clk_en_o, sys_clk_en_o, core_power_o,
          dma_l1_allow_o, async_block_o, pins_hiz_o} = prof_r;
  assign pll_mult_o     = mult_r;
  assign core_vlevel_o  = vl_r;
  assign boot_start_o   = boot_r;

  // checks; they watch synced inputs, internal state and the registered outputs
  sleep_wake_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (mode_r == opm_pkg::OPM_SLEEP && (wake_s || rtc_s) && !byp_s)
    |=> mode_r == opm_pkg::OPM_FULL_ON)
    else $error("sleep wake without bypass missed full-on");
  deep_rtc_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (mode_r == opm_pkg::OPM_DEEP_SLEEP && rtc_s && !rst_s)
    |=> mode_r == opm_pkg::OPM_ACTIVE)
    else $error("rtc wake from deep sleep missed active");
  deep_reset_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (mode_r == opm_pkg::OPM_DEEP_SLEEP && rst_s)
    |=> mode_r == opm_pkg::OPM_FULL_ON)
    else $error("reset in deep sleep missed full-on");
  deep_stay_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (mode_r == opm_pkg::OPM_DEEP_SLEEP && !rst_s && !rtc_s)
    |=> mode_r == opm_pkg::OPM_DEEP_SLEEP)
    else $error("deep sleep left without cause");
  sleep_prof_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    mode_r == opm_pkg::OPM_SLEEP |-> (!core_clk_en_o && sys_clk_en_o
    && pll_en_o && core_power_o && !dma_l1_allow_o))
    else $error("sleep profile wrong");
  hib_prof_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    mode_r == opm_pkg::OPM_HIBERNATE |-> (!core_power_o && pins_hiz_o
    && !sys_clk_en_o && !core_clk_en_o))
    else $error("hibernate profile wrong");
  full_prof_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    mode_r == opm_pkg::OPM_FULL_ON |-> (pll_en_o && !pll_bypass_o
    && core_clk_en_o && sys_clk_en_o))
    else $error("full-on profile wrong");
  mult_hold_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (mode_r == opm_pkg::OPM_ACTIVE && $past(mode_r) == opm_pkg::OPM_ACTIVE)
    |-> $stable(pll_mult_o))
    else $error("ratio changed inside active");
  no_spont_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (mode_r == opm_pkg::OPM_FULL_ON && !rq_sl && !rq_ds && !rq_ac && !wr_s)
    |=> mode_r == opm_pkg::OPM_FULL_ON)
    else $error("full-on left without request");
  boot_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (mode_r == opm_pkg::OPM_HIBERNATE && rst_s)
    |=> boot_start_o)
    else $error("reset wake did not start boot");
  act_prof_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    mode_r == opm_pkg::OPM_ACTIVE |-> (pll_bypass_o && core_clk_en_o
    && sys_clk_en_o && core_power_o && dma_l1_allow_o))
    else $error("active profile wrong");
  deep_prof_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    mode_r == opm_pkg::OPM_DEEP_SLEEP |-> (!core_clk_en_o && !sys_clk_en_o
    && !pll_en_o && async_block_o && core_power_o))
    else $error("deep sleep profile wrong");
  hib_entry_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    ((mode_r == opm_pkg::OPM_FULL_ON || mode_r == opm_pkg::OPM_ACTIVE)
    && wr_s && regulator_frequency_field_d2_r == opm_pkg::REG_REGULATOR_FREQUENCY_FIELD_OFF)
    |=> mode_r == opm_pkg::OPM_HIBERNATE)
    else $error("regulator off code missed hibernate");
  hib_wake_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (mode_r == opm_pkg::OPM_HIBERNATE && (rst_s || rtc_s))
    |=> mode_r == opm_pkg::OPM_FULL_ON)
    else $error("hibernate wake missed full-on");
  hib_stay_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (mode_r == opm_pkg::OPM_HIBERNATE && !rst_s && !rtc_s)
    |=> mode_r == opm_pkg::OPM_HIBERNATE)
    else $error("hibernate left without cause");
  // a write in the entry cycle itself replaces the pending ratio
  ratio_entry_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    ($rose(mode_r == opm_pkg::OPM_FULL_ON) && !$past(wr_s))
    |-> pll_mult_o == $past(mult_pend_r))
    else $error("pending ratio not applied on full-on entry");
  vlevel_take_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (wr_s && mode_r != opm_pkg::OPM_HIBERNATE)
    |=> core_vlevel_o == $past(vl_d2_r))
    else $error("voltage code not taken on write");
  act_stay_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (mode_r == opm_pkg::OPM_ACTIVE && !rq_sl && !rq_ds && !rq_fo && !wr_s)
    |=> mode_r == opm_pkg::OPM_ACTIVE)
    else $error("active left without request");
  sleep_stay_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    (mode_r == opm_pkg::OPM_SLEEP && !wake_s && !rtc_s)
    |=> mode_r == opm_pkg::OPM_SLEEP)
    else $error("sleep left without wake event");
  boot_cause_a: assert property (
    @(posedge mclk_i) disable iff (!rstn_i)
    boot_start_o
    |-> $past(mode_r == opm_pkg::OPM_HIBERNATE && rst_s))
    else $error("boot pulse without reset wake");

endmodule

// >>> sim/opm_ctrl_tb_top.sv
// Purpose: self-checking bench for the operating mode controller
// Assumes: every input pin passes two sync flops, answer after 3 edges
// Notes:   each event is held 4 cycles, then the bench waits 4 more
`timescale 1ns/100ps
module opm_ctrl_tb_top;
  localparam logic [7:0] P_FULL = 8'hbc;
  localparam logic [7:0] P_ACT  = 8'hfc;
  localparam logic [7:0] P_SLP  = 8'h98;
  localparam logic [7:0] P_DEEP = 8'h0a;
  localparam logic [7:0] P_HIB  = 8'h01;
  // event bits: sleep, deep, full-on, active, wake, rtc, reset pin
  localparam int S = 0, D = 1, F = 2, A = 3, W = 4, R = 5, P = 6;
  logic       mclk_i, rstn_i, pll_enable_i, pll_bypass_i, reg_write_i;
  logic [5:0] pll_mult_i, pll_mult_o;
  logic [1:0] reg_regulator_frequency_field_i;
  logic [3:0] reg_vlevel_i, core_vlevel_o;
  logic [6:0] ev;
  logic [2:0] mode_o;
  logic       pll_en_o, pll_bypass_o, core_clk_en_o, sys_clk_en_o;
  logic       core_power_o, dma_l1_allow_o, async_block_o, pins_hiz_o;
  logic       boot_start_o;
  logic [7:0] rnd;
  logic [5:0] ma, mb;
  int         failures, samples_checked, cyc, boots;

  opm_ctrl uut (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .pll_enable_i(pll_enable_i), .pll_bypass_i(pll_bypass_i),
    .pll_mult_i(pll_mult_i), .req_sleep_i(ev[S]),
    .req_deep_sleep_i(ev[D]), .req_full_on_i(ev[F]),
    .req_active_i(ev[A]), .reg_regulator_frequency_field_i(reg_regulator_frequency_field_i),
    .reg_vlevel_i(reg_vlevel_i), .reg_write_i(reg_write_i),
    .wake_i(ev[W]), .rtc_irq_i(ev[R]), .reset_pin_i(ev[P]),
    .mode_o(mode_o), .pll_en_o(pll_en_o), .pll_bypass_o(pll_bypass_o),
    .pll_mult_o(pll_mult_o), .core_clk_en_o(core_clk_en_o),
    .sys_clk_en_o(sys_clk_en_o), .core_power_o(core_power_o),
    .core_vlevel_o(core_vlevel_o), .dma_l1_allow_o(dma_l1_allow_o),
    .async_block_o(async_block_o), .pins_hiz_o(pins_hiz_o),
    .boot_start_o(boot_start_o));

  // free-running clock, 10 ns period
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // boot pulse is one cycle wide, so it is counted rather than sampled
  always @(posedge mclk_i) begin
    cyc++;
    if (boot_start_o === 1'b1) boots++;
    if (cyc == 3000) begin
      failures++;
      finish_test();
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // levels are held long enough to pass the sync flops and settle
  task automatic pulse(input int b);
    ev[b] = 1'b1;
    tick(4);
    ev[b] = 1'b0;
    tick(4);
  endtask

  task automatic wr(input logic [1:0] f, input logic [3:0] v,
                    input logic [5:0] m);
    reg_regulator_frequency_field_i   = f;
    reg_vlevel_i = v;
    pll_mult_i   = m;
    reg_write_i  = 1'b1;
    tick(4);
    reg_write_i  = 1'b0;
    tick(4);
  endtask

  // bypass and dma bits, and async_blk in hibernate, are masked where the mode leaves them open
  task automatic chk(input logic [2:0] m, input logic [7:0] e,
                     input logic [7:0] k);
    logic [7:0] p;
    p = {pll_en_o, pll_bypass_o, core_clk_en_o, sys_clk_en_o,
         core_power_o, dma_l1_allow_o, async_block_o, pins_hiz_o};
    samples_checked++;
    if (mode_o !== m || (p & k) !== (e & k)) begin
      failures++;
      $display("ERROR %0t mode %0d profile %h", $time, mode_o, p);
    end
  endtask

  task automatic cmpv(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (failures == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    rstn_i = 1'b0;
    pll_enable_i = 1'b1;
    pll_bypass_i = 1'b0;
    pll_mult_i = 6'h0a;
    reg_regulator_frequency_field_i = 2'h3;
    reg_vlevel_i = 4'h7;
    reg_write_i = 1'b0;
    ev = 7'h00;
    rnd = 8'h33;
    tick(3);
    rstn_i = 1'b1;
    tick(2);
    chk(opm_pkg::OPM_FULL_ON, P_FULL, 8'hff);
    cmpv({2'h0, pll_mult_o}, {2'h0, opm_pkg::MULT_RST});
    cmpv({4'h0, core_vlevel_o}, {4'h0, opm_pkg::VLEVEL_RST});
    // multiplier applies at once in full-on, deferred in active
    rnd = lfsr(rnd);
    ma = {rnd[5:1], 1'b1};
    wr(2'h3, rnd[3:0], ma);
    cmpv({4'h0, core_vlevel_o}, {4'h0, rnd[3:0]});
    cmpv({2'h0, pll_mult_o}, {2'h0, ma});
    pulse(A);
    chk(opm_pkg::OPM_ACTIVE, P_ACT, 8'hff);
    // software may stop the loop in active, then restarts it
    pll_enable_i = 1'b0;
    tick(4);
    chk(opm_pkg::OPM_ACTIVE, P_ACT & 8'h7f, 8'hff);
    pll_enable_i = 1'b1;
    tick(4);
    rnd = lfsr(rnd);
    mb = {rnd[4:0], 1'b0} ^ ma;
    wr(2'h3, rnd[7:4], mb);
    cmpv({2'h0, pll_mult_o}, {2'h0, ma});
    pulse(F);
    chk(opm_pkg::OPM_FULL_ON, P_FULL, 8'hff);
    cmpv({2'h0, pll_mult_o}, {2'h0, mb});
    tick(50);
    chk(opm_pkg::OPM_FULL_ON, P_FULL, 8'hff);
    // sleep entries with both bypass settings, then random ones
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      pll_bypass_i = (i < 2) ? i[0] : rnd[0];
      pulse(S);
      chk(opm_pkg::OPM_SLEEP, P_SLP, 8'hbf);
      if (i == 0) pulse(D);
      chk(opm_pkg::OPM_SLEEP, P_SLP, 8'hbf);
      pulse(i[0] ? R : W);
      if (pll_bypass_i) chk(opm_pkg::OPM_ACTIVE, P_ACT, 8'hff);
      else chk(opm_pkg::OPM_FULL_ON, P_FULL, 8'hff);
      pll_bypass_i = 1'b0;
      pulse(F);
    end
    pulse(D);
    chk(opm_pkg::OPM_DEEP_SLEEP, P_DEEP, 8'hbb);
    pulse(W);
    chk(opm_pkg::OPM_DEEP_SLEEP, P_DEEP, 8'hbb);
    pulse(F);
    chk(opm_pkg::OPM_DEEP_SLEEP, P_DEEP, 8'hbb);
    pulse(R);
    chk(opm_pkg::OPM_ACTIVE, P_ACT, 8'hff);
    pulse(D);
    pulse(P);
    chk(opm_pkg::OPM_FULL_ON, P_FULL, 8'hff);
    // regulator shut-off code enters the unpowered mode
    ma = mb;
    wr(opm_pkg::REG_REGULATOR_FREQUENCY_FIELD_OFF, 4'h2, mb);
    chk(opm_pkg::OPM_HIBERNATE, P_HIB, 8'hb9);
    pulse(W);
    chk(opm_pkg::OPM_HIBERNATE, P_HIB, 8'hb9);
    pulse(R);
    chk(opm_pkg::OPM_FULL_ON, P_FULL, 8'hff);
    cmpv({4'h0, core_vlevel_o}, {4'h0, opm_pkg::VLEVEL_RST});
    // the ratio kept outside is written back after power returns
    wr(2'h3, 4'h7, ma);
    cmpv({2'h0, pll_mult_o}, {2'h0, ma});
    wr(opm_pkg::REG_REGULATOR_FREQUENCY_FIELD_OFF, 4'h7, mb);
    boots = 0;
    pulse(P);
    chk(opm_pkg::OPM_FULL_ON, P_FULL, 8'hff);
    cmpv(boots[7:0], 8'h01);
    finish_test();
  end
endmodule
